// ### gcb_pkg.sv
// Package with register map, field positions, reset values and timing for the gauge configuration bank.
package gcb_pkg;
  // Register offsets (word addresses on the plain register port).
  localparam logic [3:0] ADDR_CFG_C = 4'h0;
  localparam logic [3:0] ADDR_CFG_D = 4'h1;
  localparam logic [3:0] ADDR_CFG_E = 4'h2;
  localparam logic [3:0] ADDR_CFG_B = 4'h3;
  localparam logic [3:0] ADDR_CMD = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_EVENT = 4'h6;
  // Reset values.
  localparam logic [7:0] RST_CFG_C = 8'h0c;
  localparam logic [7:0] RST_CFG_D = 8'hc3;
  localparam logic [7:0] RST_CFG_E = 8'h73;
  localparam logic [7:0] RST_CFG_B = 8'h40;
  // Writable bit masks; reserved bits are zero here.
  localparam logic [7:0] MASK_CFG_C = 8'h0f;
  localparam logic [7:0] MASK_CFG_D = 8'hf3;
  localparam logic [7:0] MASK_CFG_E = 8'hff;
  localparam logic [7:0] MASK_CFG_B = 8'h60;
  // Field positions in register C.
  localparam int C_CHG_PROF_IRQ = 3;
  localparam int C_SLEEP_WAKE = 2;
  localparam int C_DV_HI = 1;
  localparam int C_DV_LO = 0;
  // Field positions in register D.
  localparam int D_RELAX_SMOOTH = 7;
  localparam int D_SOC_SMOOTH = 6;
  localparam int D_STATE_PULSE = 5;
  localparam int D_OCV_PULSE = 4;
  localparam int D_EOC_DOD = 1;
  localparam int D_AMBIENT_PREDICTION_ENABLE = 0;
  // Field positions in register E.
  localparam int E_SMOOTH_SYNC = 7;
  localparam int E_IMAX_RESV = 6;
  localparam int E_IMAX_IRQ = 5;
  localparam int E_IMAX_EN = 4;
  localparam int E_DSG_FASTQ = 3;
  localparam int E_CHG_FASTQ = 2;
  localparam int E_FULL_HOLD = 1;
  localparam int E_EMPTY_HOLD = 0;
  // Field positions in register B.
  localparam int B_INSERT_DET = 6;
  localparam int B_BATLOW_IRQ = 5;
  // Command register bits.
  localparam int CMD_INSERT = 0;
  localparam int CMD_REMOVE = 1;
  localparam int CMD_PROBE = 2;
  // Delta voltage option codes.
  localparam logic [1:0] DV_STANDARD = 2'h0;
  localparam logic [1:0] DV_INSTANT = 2'h1;
  localparam logic [1:0] DV_MIN_STORED = 2'h2;
  // Timing.
  localparam longint CLK_HZ = 50000000;
  localparam longint SLOT_MS = 1000;
  localparam longint SLOT_CYCLES = (CLK_HZ * SLOT_MS) / 1000;
  localparam longint SETTLE_US = 10;
  localparam longint SETTLE_CYCLES = (CLK_HZ * SETTLE_US + 999999) / 1000000;
  localparam longint PULSE_US = 1000;
  localparam longint PULSE_CYCLES = (CLK_HZ * PULSE_US) / 1000000;
endpackage : gcb_pkg

// ### gcb_config_bank.sv
// Configuration bank with battery presence detection and event pulse output.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module gcb_config_bank #(
  parameter longint SLOT_CYCLES = gcb_pkg::SLOT_CYCLES,
  parameter longint PULSE_CYCLES = gcb_pkg::PULSE_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Battery detect pin, open drain.
  input wire logic battery_detect_pin_i,
  output logic battery_detect_pin_o,
  output logic battery_detect_pin_oe_o,
  // Algorithm events and status from the gauging core.
  input wire logic power_up_i,
  input wire logic hibernate_i,
  input wire logic waking_i,
  input wire logic relaxing_i,
  input wire logic charging_i,
  input wire logic end_of_charge_i,
  input wire logic overcharged_i,
  input wire logic soc_below_full_i,
  input wire logic therm_near_open_i,
  input wire logic charge_profile_change_i,
  input wire logic state_change_i,
  input wire logic ocv_cmd_i,
  input wire logic battery_low_i,
  input wire logic imax_update_i,
  // Feature steering outputs.
  output logic battery_present_flag_o,
  output logic charge_profile_event_o,
  output logic battery_low_event_o,
  output logic imax_event_o,
  output logic apply_sleep_comp_o,
  output logic [2:0] dv_mode_o,
  output logic smoothing_active_o,
  output logic dod_recalc_o,
  output logic ambient_pred_o,
  output logic full_hold_o,
  output logic gauge_event_pin_o
);
  // Configuration registers.
  logic [7:0] cfg_c_reg;
  logic [7:0] cfg_d_reg;
  logic [7:0] cfg_e_reg;
  logic [7:0] cfg_b_reg;
  // Synchroniser for the detect pin and the thermistor comparator.
  logic [1:0] pin_sync_reg;
  logic [1:0] therm_sync_reg;
  // Slot timer and probe control.
  logic [31:0] slot_cnt_reg;
  logic slot_tick;
  logic probe_req_reg;
  logic [31:0] pulse_cnt_reg;
  logic event_pend_reg;
  logic pulse_used_reg;
  logic cmd_insert;
  logic cmd_remove;
  logic cmd_probe;
  // Delta voltage option field, picked out once for the decoder and its check.
  logic [1:0] dv_code;

  // Write decode for the command register, one-cycle strobes.
  assign cmd_insert = reg_wr_i && (reg_addr_i == gcb_pkg::ADDR_CMD) && reg_wdata_i[gcb_pkg::CMD_INSERT];
  assign cmd_remove = reg_wr_i && (reg_addr_i == gcb_pkg::ADDR_CMD) && reg_wdata_i[gcb_pkg::CMD_REMOVE];
  assign cmd_probe = reg_wr_i && (reg_addr_i == gcb_pkg::ADDR_CMD) && reg_wdata_i[gcb_pkg::CMD_PROBE];
  assign slot_tick = (slot_cnt_reg == 32'(SLOT_CYCLES - 1));
  // The field position comes from the package, so the decoder follows any move of the field.
  assign dv_code = cfg_c_reg[gcb_pkg::C_DV_HI:gcb_pkg::C_DV_LO];

  // Configuration writes; reserved bits are masked so they never store.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cfg_c_reg <= gcb_pkg::RST_CFG_C;
      cfg_d_reg <= gcb_pkg::RST_CFG_D;
      cfg_e_reg <= gcb_pkg::RST_CFG_E;
      cfg_b_reg <= gcb_pkg::RST_CFG_B;
    end else if (reg_wr_i) begin
      if (reg_addr_i == gcb_pkg::ADDR_CFG_C) begin
        cfg_c_reg <= reg_wdata_i & gcb_pkg::MASK_CFG_C;
      end else if (reg_addr_i == gcb_pkg::ADDR_CFG_D) begin
        cfg_d_reg <= reg_wdata_i & gcb_pkg::MASK_CFG_D;
      end else if (reg_addr_i == gcb_pkg::ADDR_CFG_E) begin
        cfg_e_reg <= reg_wdata_i & gcb_pkg::MASK_CFG_E;
      end else if (reg_addr_i == gcb_pkg::ADDR_CFG_B) begin
        cfg_b_reg <= reg_wdata_i & gcb_pkg::MASK_CFG_B;
      end
    end
  end

  // Read data, valid in the cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == gcb_pkg::ADDR_CFG_C) begin
        reg_rdata_o <= cfg_c_reg;
      end else if (reg_addr_i == gcb_pkg::ADDR_CFG_D) begin
        reg_rdata_o <= cfg_d_reg;
      end else if (reg_addr_i == gcb_pkg::ADDR_CFG_E) begin
        reg_rdata_o <= cfg_e_reg;
      end else if (reg_addr_i == gcb_pkg::ADDR_CFG_B) begin
        reg_rdata_o <= cfg_b_reg;
      end else if (reg_addr_i == gcb_pkg::ADDR_STATUS) begin
        reg_rdata_o <= {5'h00, probe_req_reg, battery_detect_pin_oe_o, battery_present_flag_o};
      end else if (reg_addr_i == gcb_pkg::ADDR_EVENT) begin
        reg_rdata_o <= {6'h00, pulse_used_reg, event_pend_reg};
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Two-flop synchronisers; the first stage feeds only the second.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pin_sync_reg <= 2'h3;
      therm_sync_reg <= 2'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], battery_detect_pin_i};
      therm_sync_reg <= {therm_sync_reg[0], therm_near_open_i};
    end
  end

  // One-second slot timer, free running while powered.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || slot_tick) begin
      slot_cnt_reg <= 32'h0;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 32'h1;
    end
  end

  // The pin is never driven: the device only releases it to high impedance.
  always_ff @(posedge clk_sys_i) begin
    battery_detect_pin_o <= 1'b0;
    battery_detect_pin_oe_o <= 1'b0;
  end

  // Presence test requests are latched and served on the next slot sample.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      probe_req_reg <= 1'b1;
    end else if (slot_tick) begin
      probe_req_reg <= 1'b0;
    end else if (power_up_i || hibernate_i || cmd_probe) begin
      probe_req_reg <= 1'b1;
    end
  end

  // Presence flag: pin sampled once per slot when detection is enabled, otherwise host commands only.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      battery_present_flag_o <= 1'b0;
    end else if (cfg_b_reg[gcb_pkg::B_INSERT_DET]) begin
      if (slot_tick) begin
        if (therm_sync_reg[1]) begin
          battery_present_flag_o <= 1'b0;
        end else begin
          battery_present_flag_o <= ~pin_sync_reg[1];
        end
      end
    end else if (cmd_insert) begin
      battery_present_flag_o <= 1'b1;
    end else if (cmd_remove) begin
      battery_present_flag_o <= 1'b0;
    end
  end

  // Interrupt events, each gated by its enable.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      charge_profile_event_o <= 1'b0;
      battery_low_event_o <= 1'b0;
      imax_event_o <= 1'b0;
    end else begin
      charge_profile_event_o <= charge_profile_change_i && cfg_c_reg[gcb_pkg::C_CHG_PROF_IRQ];
      battery_low_event_o <= battery_low_i && cfg_b_reg[gcb_pkg::B_BATLOW_IRQ];
      imax_event_o <= imax_update_i && cfg_e_reg[gcb_pkg::E_IMAX_IRQ] && cfg_e_reg[gcb_pkg::E_IMAX_EN];
    end
  end

  // Feature steering decoded from the configuration bits.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      apply_sleep_comp_o <= 1'b0;
      dv_mode_o <= 3'h0;
      smoothing_active_o <= 1'b0;
      dod_recalc_o <= 1'b0;
      ambient_pred_o <= 1'b0;
    end else begin
      apply_sleep_comp_o <= waking_i && cfg_c_reg[gcb_pkg::C_SLEEP_WAKE];
      // option decode, code 11 selects nothing
      dv_mode_o <= {dv_code == gcb_pkg::DV_MIN_STORED, dv_code == gcb_pkg::DV_INSTANT,
                    dv_code == gcb_pkg::DV_STANDARD};
      smoothing_active_o <= cfg_d_reg[gcb_pkg::D_SOC_SMOOTH] && (!relaxing_i || cfg_d_reg[gcb_pkg::D_RELAX_SMOOTH]);
      dod_recalc_o <= cfg_d_reg[gcb_pkg::D_EOC_DOD] && charging_i && end_of_charge_i;
      ambient_pred_o <= cfg_d_reg[gcb_pkg::D_AMBIENT_PREDICTION_ENABLE];
    end
  end

  // Full hold: set on overcharge, released once charge falls below full.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      full_hold_o <= 1'b0;
    end else if (!cfg_e_reg[gcb_pkg::E_FULL_HOLD] || soc_below_full_i) begin
      full_hold_o <= 1'b0;
    end else if (overcharged_i) begin
      full_hold_o <= 1'b1;
    end
  end

  // Pending event collects enabled sources; a new event wins over the clear.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      event_pend_reg <= 1'b0;
    end else if ((state_change_i && cfg_d_reg[gcb_pkg::D_STATE_PULSE]) ||
                 (ocv_cmd_i && cfg_d_reg[gcb_pkg::D_OCV_PULSE])) begin
      event_pend_reg <= 1'b1;
    end else if (!pulse_used_reg && pulse_cnt_reg == 32'h0) begin
      event_pend_reg <= 1'b0;
    end
  end

  // Pulse generator: one pulse per slot; events after it in the slot merge into one pulse in the next slot.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pulse_used_reg <= 1'b0;
      pulse_cnt_reg <= 32'h0;
      gauge_event_pin_o <= 1'b0;
    end else begin
      if (pulse_cnt_reg != 32'h0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 32'h1;
        gauge_event_pin_o <= (pulse_cnt_reg != 32'h1);
      end else if (event_pend_reg && !pulse_used_reg) begin
        pulse_cnt_reg <= 32'(PULSE_CYCLES);
        gauge_event_pin_o <= 1'b1;
      end else begin
        gauge_event_pin_o <= 1'b0;
      end
      // A pulse launched on the slot boundary shows in the new slot, so its start must win over the clear.
      // Otherwise a second event in that slot would get a pulse of its own.
      if (event_pend_reg && !pulse_used_reg && pulse_cnt_reg == 32'h0) begin
        pulse_used_reg <= 1'b1;
      end else if (slot_tick) begin
        pulse_used_reg <= 1'b0;
      end
    end
  end

  // Assertions.
  property p_reset_c;
    @(posedge clk_sys_i) $fell(reset_i) |-> cfg_c_reg == 8'h0c;
  endproperty
  a_reset_c: assert property (p_reset_c) else $error("register C reset value wrong");
  property p_reset_d;
    @(posedge clk_sys_i) $fell(reset_i) |-> cfg_d_reg == 8'hc3;
  endproperty
  a_reset_d: assert property (p_reset_d) else $error("register D reset value wrong");
  property p_reset_e;
    @(posedge clk_sys_i) $fell(reset_i) |-> cfg_e_reg == 8'h73;
  endproperty
  a_reset_e: assert property (p_reset_e) else $error("register E reset value wrong");
  property p_rsvd;
    @(posedge clk_sys_i) disable iff (reset_i) cfg_c_reg[7:4] == 4'h0 && cfg_d_reg[3:2] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit stored");
  property p_cp_irq;
    @(posedge clk_sys_i) disable iff (reset_i)
      charge_profile_change_i |=> charge_profile_event_o == $past(cfg_c_reg[gcb_pkg::C_CHG_PROF_IRQ]);
  endproperty
  a_cp_irq: assert property (p_cp_irq) else $error("charge profile event gating wrong");
  property p_bl_irq;
    @(posedge clk_sys_i) disable iff (reset_i) battery_low_event_o |-> $past(cfg_b_reg[gcb_pkg::B_BATLOW_IRQ]);
  endproperty
  a_bl_irq: assert property (p_bl_irq) else $error("battery low event while disabled");
  property p_smooth;
    @(posedge clk_sys_i) disable iff (reset_i) smoothing_active_o |-> $past(cfg_d_reg[gcb_pkg::D_SOC_SMOOTH]);
  endproperty
  a_smooth: assert property (p_smooth) else $error("smoothing active while disabled");
  property p_host_only;
    @(posedge clk_sys_i) disable iff (reset_i)
      !cfg_b_reg[gcb_pkg::B_INSERT_DET] && !cmd_insert |=> !$rose(battery_present_flag_o);
  endproperty
  a_host_only: assert property (p_host_only) else $error("presence set without host command");
  property p_sample_slot;
    @(posedge clk_sys_i) disable iff (reset_i)
      $changed(battery_present_flag_o) && $past(cfg_b_reg[gcb_pkg::B_INSERT_DET]) |-> $past(slot_tick);
  endproperty
  a_sample_slot: assert property (p_sample_slot) else $error("presence changed outside slot sample");
  property p_one_pulse;
    @(posedge clk_sys_i) disable iff (reset_i) $rose(gauge_event_pin_o) |-> $past(!pulse_used_reg);
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("second pulse in one slot");
  property p_pin_hiz;
    @(posedge clk_sys_i) disable iff (reset_i) !battery_detect_pin_oe_o;
  endproperty
  a_pin_hiz: assert property (p_pin_hiz) else $error("detect pin driven");
  // A pulse that starts marks its slot as used at once, even on the slot boundary.
  property p_pulse_marks_slot;
    @(posedge clk_sys_i) disable iff (reset_i) $rose(gauge_event_pin_o) |-> pulse_used_reg;
  endproperty
  a_pulse_marks_slot: assert property (p_pulse_marks_slot) else $error("pulse left its slot unmarked");
  // With detection on, the flag moves only on a slot sample; host commands have no effect.
  property p_flag_hold;
    @(posedge clk_sys_i) disable iff (reset_i)
      cfg_b_reg[gcb_pkg::B_INSERT_DET] && !slot_tick |=> $stable(battery_present_flag_o);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("presence moved between samples");
  // The unused option code selects no delta voltage mode at all.
  property p_dv_unused;
    @(posedge clk_sys_i) disable iff (reset_i) (&dv_code) |=> dv_mode_o == 3'h0;
  endproperty
  a_dv_unused: assert property (p_dv_unused) else $error("unused option code selected a mode");
  // Falling below full always ends the hold in the next cycle.
  property p_hold_release;
    @(posedge clk_sys_i) disable iff (reset_i) soc_below_full_i |=> !full_hold_o;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("full hold kept below full");
  c_pulse: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(gauge_event_pin_o));
  c_present: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(battery_present_flag_o));
  c_hold: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(full_hold_o));
  // A presence test requested between slot samples.
  c_probe: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(probe_req_reg));
endmodule : gcb_config_bank

// ### gcb_pack_model.sv
// Battery pack model: weak pull-up on the detect wire and a pack that grounds it.
`timescale 1ns/1ps
module gcb_pack_model (
  // Design side of the open-drain detect pin.
  input wire logic pin_o_i,
  input wire logic pin_oe_i,
  // Pack state chosen by the bench.
  input wire logic battery_in_i,
  // Resolved wire level fed back to the design.
  output logic pin_level_o
);
  // pull-up, pack grounds
  // The pull-up only wins while nobody grounds the wire, so an absent pack reads high.
  assign pin_level_o = (battery_in_i || (pin_oe_i && !pin_o_i)) ? 1'b0 : 1'b1;
endmodule : gcb_pack_model

// ### tb_top.sv
// Self-checking bench for the gauge configuration bank.
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  // Short slot and pulse keep the run brief; every timing expectation derives from them.
  localparam int SLOT = 64;
  localparam int PULSE = 4;
  int fail_count = 0;
  int comparisons = 0;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic pin_level, pin_o, pin_oe;
  logic battery_in = 1'b0;
  logic power_up_i = 1'b0, hibernate_i = 1'b0, waking_i = 1'b0, relaxing_i = 1'b0;
  logic charging_i = 1'b0, end_of_charge_i = 1'b0, overcharged_i = 1'b0, soc_below_full_i = 1'b0;
  logic therm_near_open_i = 1'b0, charge_profile_change_i = 1'b0, state_change_i = 1'b0;
  logic ocv_cmd_i = 1'b0, battery_low_i = 1'b0, imax_update_i = 1'b0;
  logic flag, cp_ev, bl_ev, imax_ev, sleep_comp, smooth, dod, amb, hold, ev_pin;
  logic [2:0] dv_mode;

  // Clock at 50 MHz.
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  gcb_pack_model i_pack (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .battery_in_i(battery_in), .pin_level_o(pin_level));

  gcb_config_bank #(.SLOT_CYCLES(SLOT), .PULSE_CYCLES(PULSE)) i_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .battery_detect_pin_i(pin_level),
    .battery_detect_pin_o(pin_o), .battery_detect_pin_oe_o(pin_oe), .power_up_i(power_up_i),
    .hibernate_i(hibernate_i), .waking_i(waking_i), .relaxing_i(relaxing_i), .charging_i(charging_i),
    .end_of_charge_i(end_of_charge_i), .overcharged_i(overcharged_i), .soc_below_full_i(soc_below_full_i),
    .therm_near_open_i(therm_near_open_i), .charge_profile_change_i(charge_profile_change_i),
    .state_change_i(state_change_i), .ocv_cmd_i(ocv_cmd_i), .battery_low_i(battery_low_i),
    .imax_update_i(imax_update_i), .battery_present_flag_o(flag), .charge_profile_event_o(cp_ev),
    .battery_low_event_o(bl_ev), .imax_event_o(imax_ev), .apply_sleep_comp_o(sleep_comp), .dv_mode_o(dv_mode),
    .smoothing_active_o(smooth), .dod_recalc_o(dod), .ambient_pred_o(amb), .full_hold_o(hold),
    .gauge_event_pin_o(ev_pin));

  // One-cycle register write; the strobe drops at the edge that takes it.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // One-cycle read; the data stand only in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  // Let n edges pass and step off the edge so registered outputs are settled.
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : settle

  // One-cycle event pulse; returns where the registered answer is visible.
  task automatic fire(input int sel);
    @(posedge clk_sys_i);
    case (sel)
      0: charge_profile_change_i <= 1'b1;
      1: battery_low_i <= 1'b1;
      2: imax_update_i <= 1'b1;
      3: state_change_i <= 1'b1;
      default: ocv_cmd_i <= 1'b1;
    endcase
    @(posedge clk_sys_i);
    {charge_profile_change_i, battery_low_i, imax_update_i, state_change_i, ocv_cmd_i} <= 5'h00;
    #1;
  endtask : fire

  // Bounded wait for the presence flag; n is the number of cycles spent.
  task automatic wait_flag(input logic v, output int n);
    n = 0;
    while (flag !== v && n < 3 * SLOT) begin
      settle(1);
      n++;
    end
  endtask : wait_flag

  // Count rising edges and high cycles of the event pin.
  task automatic count_pin(input int cycles, output int rises, output int high);
    logic prev;
    rises = 0;
    high = 0;
    prev = ev_pin;
    repeat (cycles) begin
      settle(1);
      if (ev_pin === 1'b1) high++;
      if (ev_pin === 1'b1 && prev !== 1'b1) rises++;
      prev = ev_pin;
    end
  endtask : count_pin

  // Reset values, an unmapped read and reserved bits.
  task automatic t_regs();
    logic [7:0] d;
    rd(gcb_pkg::ADDR_CFG_C, d);
    `CHK(d, 8'h0c)
    rd(gcb_pkg::ADDR_CFG_D, d);
    `CHK(d, 8'hc3)
    rd(gcb_pkg::ADDR_CFG_E, d);
    `CHK(d, 8'h73)
    rd(4'h7, d);
    `CHK(d, 8'h00)
    wr(gcb_pkg::ADDR_CFG_C, 8'hff);
    rd(gcb_pkg::ADDR_CFG_C, d);
    `CHK(d, 8'h0f)
    wr(gcb_pkg::ADDR_CFG_D, 8'hff);
    rd(gcb_pkg::ADDR_CFG_D, d);
    `CHK(d, 8'hf3)
    wr(gcb_pkg::ADDR_CFG_E, 8'h00);
    rd(gcb_pkg::ADDR_CFG_E, d);
    `CHK(d, 8'h00)
    wr(gcb_pkg::ADDR_CFG_E, 8'h73);
    $display("done register defaults");
  endtask : t_regs

  // Every delta voltage code, then smoothing, recalculation and prediction enables.
  task automatic t_features();
    logic [2:0] exp_mode [4] = '{3'b001, 3'b010, 3'b100, 3'b000};
    for (int i = 0; i < 4; i++) begin
      wr(gcb_pkg::ADDR_CFG_C, 8'h0c | 8'(i));
      settle(2);
      `CHK(dv_mode, exp_mode[i])
    end
    for (int i = 0; i < 8; i++) begin
      wr(gcb_pkg::ADDR_CFG_D, {i[2], i[1], 6'h03});
      relaxing_i <= i[0];
      settle(3);
      `CHK(smooth, i[1] & (!i[0] | i[2]))
      `CHK(amb, 1'b1)
    end
    charging_i <= 1'b1;
    end_of_charge_i <= 1'b1;
    settle(2);
    `CHK(dod, 1'b1)
    charging_i <= 1'b0;
    settle(2);
    `CHK(dod, 1'b0)
    wr(gcb_pkg::ADDR_CFG_D, 8'h00);
    settle(2);
    `CHK(amb, 1'b0)
    $display("done feature enables");
  endtask : t_features

  // Charge profile, battery low and wake compensation follow their enables; the imax event and full hold are checked with theirs on.
  task automatic t_events();
    wr(gcb_pkg::ADDR_CFG_C, 8'h08);
    fire(0);
    `CHK(cp_ev, 1'b1)
    wr(gcb_pkg::ADDR_CFG_C, 8'h00);
    fire(0);
    `CHK(cp_ev, 1'b0)
    wr(gcb_pkg::ADDR_CFG_B, 8'h60);
    fire(1);
    `CHK(bl_ev, 1'b1)
    wr(gcb_pkg::ADDR_CFG_B, 8'h40);
    fire(1);
    `CHK(bl_ev, 1'b0)
    fire(2);
    `CHK(imax_ev, 1'b1)
    wr(gcb_pkg::ADDR_CFG_C, 8'h04);
    waking_i <= 1'b1;
    settle(2);
    `CHK(sleep_comp, 1'b1)
    wr(gcb_pkg::ADDR_CFG_C, 8'h00);
    settle(2);
    `CHK(sleep_comp, 1'b0)
    waking_i <= 1'b0;
    overcharged_i <= 1'b1;
    settle(1);
    overcharged_i <= 1'b0;
    settle(2);
    `CHK(hold, 1'b1)
    soc_below_full_i <= 1'b1;
    settle(1);
    soc_below_full_i <= 1'b0;
    settle(2);
    `CHK(hold, 1'b0)
    $display("done events");
  endtask : t_events

  // Detection off: the pin is ignored and only host commands move the flag.
  task automatic t_host();
    wr(gcb_pkg::ADDR_CFG_B, 8'h00);
    battery_in <= 1'b1;
    settle(SLOT + 8);
    `CHK(flag, 1'b0)
    wr(gcb_pkg::ADDR_CMD, 8'h01);
    settle(2);
    `CHK(flag, 1'b1)
    wr(gcb_pkg::ADDR_CMD, 8'h02);
    settle(2);
    `CHK(flag, 1'b0)
    battery_in <= 1'b0;
    $display("done host commands");
  endtask : t_host

  // Detection on: released pin, low means present, thermistor open wins, one sample a slot.
  task automatic t_pin();
    int n;
    logic [7:0] d;
    wr(gcb_pkg::ADDR_CFG_B, 8'h40);
    wr(gcb_pkg::ADDR_CMD, 8'h01);
    settle(2);
    `CHK(flag, 1'b0)
    battery_in <= 1'b1;
    wait_flag(1'b1, n);
    `CHK(flag, 1'b1)
    `CHK(pin_oe, 1'b0)
    rd(gcb_pkg::ADDR_STATUS, d);
    `CHK(d, 8'h01)
    hibernate_i <= 1'b1;
    settle(1);
    hibernate_i <= 1'b0;
    rd(gcb_pkg::ADDR_STATUS, d);
    `CHK(d, 8'h05)
    therm_near_open_i <= 1'b1;
    wait_flag(1'b0, n);
    `CHK(flag, 1'b0)
    rd(gcb_pkg::ADDR_STATUS, d);
    `CHK(d, 8'h00)
    wr(gcb_pkg::ADDR_CMD, 8'h04);
    rd(gcb_pkg::ADDR_STATUS, d);
    `CHK(d, 8'h04)
    therm_near_open_i <= 1'b0;
    wait_flag(1'b1, n);
    battery_in <= 1'b0;
    wait_flag(1'b0, n);
    `CHK(n > SLOT - 4 && n <= SLOT + 4, 1'b1)
    $display("done pin detection");
  endtask : t_pin

  // Event pin: pulse width, one pulse a slot, deferral and gating.
  task automatic t_pulse();
    int n, rises, high;
    logic [7:0] d;
    wr(gcb_pkg::ADDR_CFG_D, 8'h30);
    battery_in <= 1'b1;
    wait_flag(1'b1, n);
    fire(3);
    count_pin(10, rises, high);
    `CHK(rises, 1)
    `CHK(high, PULSE)
    rd(gcb_pkg::ADDR_EVENT, d);
    `CHK(d, 8'h02)
    fire(4);
    count_pin(SLOT - 30, rises, high);
    `CHK(rises, 0)
    count_pin(SLOT, rises, high);
    `CHK(rises, 1)
    wr(gcb_pkg::ADDR_CFG_D, 8'h00);
    fire(3);
    fire(4);
    count_pin(2 * SLOT, rises, high);
    `CHK(rises, 0)
    // Align on a slot sample, then launch a pulse exactly on the next slot boundary.
    battery_in <= 1'b0;
    wait_flag(1'b0, n);
    wr(gcb_pkg::ADDR_CFG_D, 8'h30);
    settle(SLOT - 5);
    fire(3);
    fire(4);
    count_pin(40, rises, high);
    `CHK(rises, 0)
    $display("done event pin");
  endtask : t_pulse

  // Single place where the run ends.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog of 40 slots plus 2000 cycles, well above the roughly fourteen slots' worth the tests need.
  initial begin
    repeat (40 * SLOT + 2000) @(posedge clk_sys_i);
    fail_count++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_regs();
    t_features();
    t_events();
    t_host();
    t_pin();
    t_pulse();
    tally_and_finish();
  end
endmodule : tb_top
